// ---- hdl/sai_map.svh ----
// register offsets, field positions, reset values and timing counts for the aux outputs
`ifndef SAI_MAP_SVH
`define SAI_MAP_SVH
`define SAI_OFF_SYSCTL      8'h80
`define SAI_OFF_ROUTE       8'h8c
`define SAI_OFF_PWRSTAT     8'h90
`define SAI_OFF_STATUS      8'h94
`define SAI_SYSCTL_OSC_BIT  27
`define SAI_SYSCTL_RST      32'h0000_0000
`define SAI_ROUTE_RST       32'h0000_0000
`define SAI_PWRSTAT_RST     8'h00
`define SAI_ROUTE_P1_LSB    4
`define SAI_ROUTE_P2_LSB    8
`define SAI_ROUTE_P6_LSB    24
`define SAI_ROUTE_P7_LSB    28
`define SAI_SEL_SLEEP       3'h4
`define SAI_SEL_LED0        3'h2
`define SAI_SEL_LED1        3'h3
`define SAI_PS_F0_D3        0
`define SAI_PS_F1_D3        1
`define SAI_PS_F0_PME       2
`define SAI_PS_F1_PME       3
`define SAI_PS_MODE0_IO     4
`define SAI_PS_MODE0_CB     5
`define SAI_PS_MODE1_IO     6
`define SAI_PS_MODE1_CB     7
`define SAI_LED_HOLD_MS     64
`define SAI_CLK_HZ          40000000
`define SAI_OSC_HZ          16000
`endif

// ---- hdl/sai_pkg.sv ----
// types shared by the aux indicator outputs
package sai_pkg;
   typedef logic [7:0]  sai_addr_t;
   typedef logic [31:0] sai_word_t;
   typedef logic [2:0]  sai_sel_t;
endpackage : sai_pkg

// ---- hdl/sai_aux_outputs.sv ----
// auxiliary socket outputs: sleep indicator, audio combiner, activity leds, ring oscillator
//
// Overview of operation
// (R1) sleep indicator high only when both functions in D3 and PME enabled on either
// (R2) sleep indicator appears on a multipurpose pin whose routing field equals 100b
// (R3) ring oscillator about 16 kHz, enabled only by system control bit 27, off at reset
// (R4) oscillator-timed logic can power down and interrogate cards without PCI clock
// (R5) clock source select clear makes switch clock an input, set drives oscillator out
// (R6) 16-bit io card uses BVD2 as audio input, CardBus card uses CAUDIO
// (R7) combined audio output is XOR of both sockets' binary audio
// (R8) activity leds exist only when routed; then driven actively high and low
// (R9) first led shows socket 0 accesses, second socket 1; active high
// (R10) socket access drives its led high 64 ms by counter, then low
// (R11) further access while counting restarts the counter
// (R12) leds forced low while suspend asserted or clock stop pending
// (R13) led counter runs on PCI clock; terminal count derived from clock rate
//
// Local design decisions: the strobed register port and the register addresses.

`timescale 1ns/100ps
`include "sai_map.svh"
module sai_aux_outputs #(
   parameter int CLK_HZ      = `SAI_CLK_HZ,
   parameter int LED_HOLD_MS = `SAI_LED_HOLD_MS,
   parameter int LED_CYCLES  = CLK_HZ / 1000 * LED_HOLD_MS,
   parameter int OSC_HALF    = CLK_HZ / (2 * `SAI_OSC_HZ)
) (
   input  wire logic            i_ref_clk,
   input  wire logic            i_reset_n,
   input  wire logic            i_clk_en,
   input  wire sai_pkg::sai_addr_t i_addr,
   input  wire sai_pkg::sai_word_t i_wdata,
   input  wire logic            i_wr,
   input  wire logic            i_rd,
   output sai_pkg::sai_word_t   o_rdata,
   input  wire logic            i_sock0_bvd2,
   input  wire logic            i_sock0_caudio,
   input  wire logic            i_sock1_bvd2,
   input  wire logic            i_sock1_caudio,
   input  wire logic            i_sock0_access,
   input  wire logic            i_sock1_access,
   input  wire logic            i_suspend,
   input  wire logic            i_clkrun_stop,
   input  wire logic            i_switch_clock_in,
   output logic                 o_switch_clock_out,
   output logic                 o_switch_clock_oe,
   output logic                 o_combined_audio_out,
   output logic [3:0]           o_multipurpose_pin,
   output logic [3:0]           o_multipurpose_pin_oe
);
   import sai_pkg::*;

   // counter widths follow the parameters so a 64 ms hold at the bus clock still fits
   localparam int LED_W = $clog2(LED_CYCLES + 1);
   localparam int OSC_W = $clog2(OSC_HALF + 1);
   localparam logic [LED_W-1:0] LED_TC = LED_W'(LED_CYCLES);
   localparam logic [OSC_W-1:0] OSC_TC = OSC_W'(OSC_HALF);

   // reset copy, two flops deep
   logic               rst_s1_r;
   logic               rst_n_r;

   // software-visible registers
   sai_word_t          sysctl_r;
   sai_word_t          route_r;
   logic [7:0]         pwrstat_r;

   // indicator and oscillator state
   logic               sleep_r;
   logic [LED_W-1:0]   led0_cnt_r;
   logic [LED_W-1:0]   led1_cnt_r;
   logic               led0_r;
   logic               led1_r;
   logic [OSC_W-1:0]   osc_cnt_r;
   logic               osc_r;
   logic               ext_clk_r;
   logic               probe_clk_r;

   // internal decodes
   logic               osc_en;
   logic               led_kill;
   logic               aud0_w;
   logic               aud1_w;
   logic [5:0]         status_w;

   // pick a 3-bit routing field for pin n (0..3 = pins one, two, six, seven)
   function automatic sai_sel_t route_sel(input sai_word_t r, input int n);
      case (n)
         0:       route_sel = r[`SAI_ROUTE_P1_LSB +: 3];
         1:       route_sel = r[`SAI_ROUTE_P2_LSB +: 3];
         2:       route_sel = r[`SAI_ROUTE_P6_LSB +: 3];
         default: route_sel = r[`SAI_ROUTE_P7_LSB +: 3];
      endcase
   endfunction : route_sel

   // choose audio source from card mode; memory cards contribute nothing
   function automatic logic card_audio_in(input logic io, input logic cb,
                                          input logic bvd2, input logic caudio);
      card_audio_in = (io & bvd2) | (cb & caudio); // see (R6)
   endfunction : card_audio_in

   // reset release through two flops
   // assertion reaches every flop at once; release is clocked to avoid recovery races
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   // register writes
   // unmapped offsets are ignored on write and read back as zero
   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sysctl_r  <= `SAI_SYSCTL_RST; // see (R3)
         route_r   <= `SAI_ROUTE_RST;
         pwrstat_r <= `SAI_PWRSTAT_RST;
      end else if (i_clk_en && i_wr) begin
         case (i_addr)
            `SAI_OFF_SYSCTL:  sysctl_r  <= i_wdata;
            `SAI_OFF_ROUTE:   route_r   <= i_wdata;
            `SAI_OFF_PWRSTAT: pwrstat_r <= i_wdata[7:0];
            default: ;
         endcase
      end
   end

   // read data stands the cycle after the strobe only
   // status is a snapshot; its bits may move between strobe and data
   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_clk_en) begin
         o_rdata <= 32'h0000_0000;
         if (i_rd) begin
            case (i_addr)
               `SAI_OFF_SYSCTL:  o_rdata <= sysctl_r;
               `SAI_OFF_ROUTE:   o_rdata <= route_r;
               `SAI_OFF_PWRSTAT: o_rdata <= {24'h00_0000, pwrstat_r};
               `SAI_OFF_STATUS:  o_rdata <= {26'h0, status_w};
               default:          o_rdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign osc_en   = sysctl_r[`SAI_SYSCTL_OSC_BIT]; // see (R3)
   assign led_kill = i_suspend | i_clkrun_stop;
   // status snapshot; bit 5 is the card probe clock level, bit 4 the sampled external clock terminal
   assign status_w = {probe_clk_r, ext_clk_r, osc_r, led1_r, led0_r, sleep_r};
   assign aud0_w   = card_audio_in(pwrstat_r[`SAI_PS_MODE0_IO], pwrstat_r[`SAI_PS_MODE0_CB],
                                   i_sock0_bvd2, i_sock0_caudio);
   assign aud1_w   = card_audio_in(pwrstat_r[`SAI_PS_MODE1_IO], pwrstat_r[`SAI_PS_MODE1_CB],
                                   i_sock1_bvd2, i_sock1_caudio);

   // sleep state indicator
   // registered so the pin sees a clean level two cycles behind the power register (sleep_r, then the pin flop)
   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sleep_r <= 1'b0;
      end else if (i_clk_en) begin
         sleep_r <= pwrstat_r[`SAI_PS_F0_D3] & pwrstat_r[`SAI_PS_F1_D3]
                  & (pwrstat_r[`SAI_PS_F0_PME] | pwrstat_r[`SAI_PS_F1_PME]); // see (R1)
      end
   end

   // ring oscillator stand-in: a divider; a free-running source needs no PCI bus traffic
   // OSC_HALF sets the half period; its default gives about 16 kHz
   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         osc_cnt_r <= '0;
         osc_r     <= 1'b0;
      end else if (i_clk_en) begin
         if (!osc_en) begin
            osc_cnt_r <= '0;
            osc_r     <= 1'b0; // see (R3)
         end else if (osc_cnt_r >= OSC_TC - OSC_W'(1)) begin
            osc_cnt_r <= '0;
            osc_r     <= ~osc_r; // see (R4)
         end else begin
            osc_cnt_r <= osc_cnt_r + OSC_W'(1);
         end
      end
   end

   // switch clock terminal direction
   // driver held off until the select bit is set so a board clock never fights ours
   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_switch_clock_out <= 1'b0;
         o_switch_clock_oe  <= 1'b0;
      end else if (i_clk_en) begin
         o_switch_clock_oe  <= osc_en;         // see (R5)
         o_switch_clock_out <= osc_en & osc_r; // see (R5)
      end
   end

   // external clock terminal, sampled as a level; the board pull-down keeps it low when idle
   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ext_clk_r <= 1'b0;
      end else if (i_clk_en) begin
         ext_clk_r <= i_switch_clock_in & ~osc_en; // see (R5)
      end
   end

   // card probe clock: internal oscillator when enabled, else the external terminal,
   // so probing keeps going with no bus clock traffic
   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         probe_clk_r <= 1'b0;
      end else if (i_clk_en) begin
         probe_clk_r <= osc_en ? osc_r : ext_clk_r; // see (R4)
      end
   end

   // audio combiner
   // memory cards feed 0, so two idle sockets give a quiet speaker
   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_combined_audio_out <= 1'b0;
      end else if (i_clk_en) begin
         o_combined_audio_out <= aud0_w ^ aud1_w; // see (R7)
      end
   end

   // socket 0 led hold counter, retriggered by each access
   // kill wins over access so a stopped bus clock never leaves a led lit
   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         led0_cnt_r <= '0;
         led0_r     <= 1'b0;
      end else if (i_clk_en) begin
         if (led_kill) begin
            led0_cnt_r <= '0;
            led0_r     <= 1'b0; // see (R12)
         end else if (i_sock0_access) begin
            led0_cnt_r <= LED_TC; // see (R10) see (R11) see (R13)
            led0_r     <= 1'b1;   // see (R9)
         end else if (led0_cnt_r > LED_W'(1)) begin
            led0_cnt_r <= led0_cnt_r - LED_W'(1);
         end else begin
            led0_cnt_r <= '0;
            led0_r     <= 1'b0; // see (R10)
         end
      end
   end

   // socket 1 led hold counter
   // same as socket 0; kept apart so each socket's timing is visible
   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         led1_cnt_r <= '0;
         led1_r     <= 1'b0;
      end else if (i_clk_en) begin
         if (led_kill) begin
            led1_cnt_r <= '0;
            led1_r     <= 1'b0; // see (R12)
         end else if (i_sock1_access) begin
            led1_cnt_r <= LED_TC; // see (R11)
            led1_r     <= 1'b1;   // see (R9)
         end else if (led1_cnt_r > LED_W'(1)) begin
            led1_cnt_r <= led1_cnt_r - LED_W'(1);
         end else begin
            led1_cnt_r <= '0;
            led1_r     <= 1'b0;
         end
      end
   end

   // multipurpose pin muxing; an unrouted pin is left undriven
   // an unrouted pin parks at 0 with oe low and relies on the board for its level
   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_multipurpose_pin    <= 4'h0;
         o_multipurpose_pin_oe <= 4'h0;
      end else if (i_clk_en) begin
         for (int n = 0; n < 4; n++) begin
            case (route_sel(route_r, n))
               `SAI_SEL_SLEEP: begin
                  o_multipurpose_pin[n]    <= sleep_r; // see (R2)
                  o_multipurpose_pin_oe[n] <= 1'b1;
               end
               `SAI_SEL_LED0: begin
                  o_multipurpose_pin[n]    <= led0_r; // see (R8)
                  o_multipurpose_pin_oe[n] <= 1'b1;
               end
               `SAI_SEL_LED1: begin
                  o_multipurpose_pin[n]    <= led1_r; // see (R8)
                  o_multipurpose_pin_oe[n] <= 1'b1;
               end
               default: begin
                  o_multipurpose_pin[n]    <= 1'b0;
                  o_multipurpose_pin_oe[n] <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule : sai_aux_outputs

// ---- dv/sai_aux_chk_sva.sv ----
// port assertions for the aux indicator outputs
`timescale 1ns/100ps
module sai_aux_chk #(
   parameter int OSC_HALF   = 4,
   parameter int LED_CYCLES = 20
) (
   input wire logic               i_ref_clk,
   input wire logic               i_reset_n,
   input wire logic               i_clk_en,
   input wire sai_pkg::sai_addr_t i_addr,
   input wire sai_pkg::sai_word_t i_wdata,
   input wire logic               i_wr,
   input wire logic               i_sock0_bvd2,
   input wire logic               i_sock0_caudio,
   input wire logic               i_sock1_bvd2,
   input wire logic               i_sock1_caudio,
   input wire logic               i_sock0_access,
   input wire logic               i_suspend,
   input wire logic               i_clkrun_stop,
   input wire logic               o_switch_clock_out,
   input wire logic               o_switch_clock_oe,
   input wire logic               o_combined_audio_out,
   input wire logic [3:0]         o_multipurpose_pin,
   input wire logic [3:0]         o_multipurpose_pin_oe
);
   import sai_pkg::*;
   localparam int OSC_WIN = OSC_HALF + 1;
   localparam int LED_MAX = LED_CYCLES + 3;
   sai_word_t  sys_r, rte_r;
   logic [7:0] ps_r;
   logic [3:0] hist_r, en_w;
   logic [2:0] quiet_r;
   int         idle_r;
   logic       ok, aud_w, slp_w, cut_w;
   function automatic logic drv(logic [2:0] s);
      return s == 3'h4 || s == 3'h2 || s == 3'h3;
   endfunction : drv
   assign ok    = &hist_r && quiet_r == 3'h7;
   assign aud_w = (ps_r[4] ? i_sock0_bvd2 : ps_r[5] & i_sock0_caudio)
                ^ (ps_r[6] ? i_sock1_bvd2 : ps_r[7] & i_sock1_caudio);
   assign slp_w = ps_r[0] & ps_r[1] & (ps_r[2] | ps_r[3]);
   assign cut_w = i_suspend | i_clkrun_stop;
   assign en_w  = {drv(rte_r[30:28]), drv(rte_r[26:24]), drv(rte_r[10:8]), drv(rte_r[6:4])};
   // mirrors frozen with the clock enable, as the block's own registers are
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         {sys_r, rte_r, ps_r, hist_r, quiet_r} <= '0;
         idle_r <= 1000;
      end else begin
         hist_r <= {hist_r[2:0], i_clk_en};
         if (i_clk_en) begin
            idle_r  <= i_sock0_access ? 0 : (idle_r < 1000 ? idle_r + 1 : idle_r);
            quiet_r <= (i_wr && i_addr inside {8'h80, 8'h8c, 8'h90}) ? 3'h0 :
                       (quiet_r == 3'h7 ? quiet_r : quiet_r + 3'h1);
            if (i_wr && i_addr == 8'h80) sys_r <= i_wdata;
            if (i_wr && i_addr == 8'h8c) rte_r <= i_wdata;
            if (i_wr && i_addr == 8'h90) ps_r <= i_wdata[7:0];
         end
      end
   end
   default clocking cb_d @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_reset_n);
   chk_audio_xor: assert property (ok |-> o_combined_audio_out == $past(aud_w))
      else $error("audio out is not the xor");
   chk_osc_enable: assert property (ok |-> o_switch_clock_oe == sys_r[27])
      else $error("clock pin direction wrong");
   chk_osc_runs: assert property (ok && sys_r[27] |-> ##[0:OSC_WIN] $changed(o_switch_clock_out))
      else $error("oscillator output stalled");
   chk_pin_oe: assert property (ok |-> o_multipurpose_pin_oe == en_w)
      else $error("pin enable differs from routing");
   chk_sleep_pin: assert property (ok && rte_r[26:24] == 3'h4 |-> o_multipurpose_pin[2] == slp_w)
      else $error("sleep indicator wrong");
   chk_led_rise: assert property ((ok && i_sock0_access && !cut_w && rte_r[6:4] == 3'h2)
      ##1 (!cut_w)[*2] |=> o_multipurpose_pin[0])
      else $error("led did not light");
   chk_led_cut: assert property (ok && rte_r[6:4] == 3'h2 && $past(cut_w) && $past(cut_w, 2)
      && $past(cut_w, 3) |-> !o_multipurpose_pin[0])
      else $error("led lit while cut off");
   chk_led_expiry: assert property (&hist_r && rte_r[6:4] == 3'h2 && idle_r > LED_MAX
      |-> !o_multipurpose_pin[0])
      else $error("led held too long");
endmodule : sai_aux_chk
bind sai_aux_outputs sai_aux_chk #(.OSC_HALF(OSC_HALF), .LED_CYCLES(LED_CYCLES)) u_chk (.*);

// ---- dv/sai_sock_model.sv ----
// socket model: two cards putting audio on the pin their mode uses
`timescale 1ns/100ps
module sai_sock_model (
   input  wire logic [1:0] i_level,
   input  wire logic [1:0] i_cardbus,
   output logic [1:0]      o_bvd2,
   output logic [1:0]      o_caudio
);
   // the unused pin carries the inverse so a wrong pick is seen
   assign o_bvd2   = i_level ^ i_cardbus;
   assign o_caudio = i_level ^ ~i_cardbus;
endmodule : sai_sock_model

// ---- dv/testbench.sv ----
// bench for the aux indicator outputs
`timescale 1ns/100ps
module testbench;
   import sai_pkg::*;
   localparam int LC = 20;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, a0 = 0, a1 = 0, susp = 0, stop = 0, ext = 0;
   logic [1:0] lvl = 0, cb = 0, bvd, cau;
   sai_addr_t  adr = '0;
   sai_word_t  wd = '0, rdat;
   logic       so, soe, aud;
   logic [3:0] pin, poe;
   int miscompares = 0, n_checks = 0;
   initial forever #12.5 clk = ~clk;
   sai_sock_model u_sock (.i_level(lvl), .i_cardbus(cb), .o_bvd2(bvd), .o_caudio(cau));
   sai_aux_outputs #(.LED_CYCLES(LC), .OSC_HALF(4)) dut (.i_ref_clk(clk), .i_reset_n(rst_n),
      .i_clk_en(1'b1), .i_addr(adr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat),
      .i_sock0_bvd2(bvd[0]), .i_sock0_caudio(cau[0]), .i_sock1_bvd2(bvd[1]),
      .i_sock1_caudio(cau[1]), .i_sock0_access(a0), .i_sock1_access(a1), .i_suspend(susp),
      .i_clkrun_stop(stop), .i_switch_clock_in(ext), .o_switch_clock_out(so),
      .o_switch_clock_oe(soe), .o_combined_audio_out(aud), .o_multipurpose_pin(pin),
      .o_multipurpose_pin_oe(poe));
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic wr32(sai_addr_t a, sai_word_t d);
      @(posedge clk);
      adr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      cyc(3);
   endtask : wr32
   task automatic rdchk(sai_addr_t a, sai_word_t e);
      @(posedge clk);
      adr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("read", rdat, e);
   endtask : rdchk
   task automatic hit(bit s, int n);
      @(posedge clk);
      a0 <= !s;
      a1 <= s;
      @(posedge clk);
      a0 <= 1'b0;
      a1 <= 1'b0;
      cyc(n);
   endtask : hit
   task automatic t_osc();
      int tg;
      logic pv;
      rdchk(8'h80, 32'h0);
      chk("clk oe off", soe, 0);
      @(posedge clk);
      ext <= 1'b1;
      cyc(2);
      rdchk(8'h94, 32'h30);
      @(posedge clk);
      ext <= 1'b0;
      wr32(8'h80, 32'h0800_0000);
      chk("clk oe on", soe, 1);
      tg = 0;
      pv = so;
      for (int i = 0; i < 16; i++) begin
         cyc(1);
         tg += (so != pv);
         pv = so;
      end
      chk("osc toggles", tg, 4);
      wr32(8'h80, 32'h0);
      chk("clk oe back", soe, 0);
      chk("clk out idle", so, 0);
      wr32(8'h44, 32'hffff_ffff);
      rdchk(8'h44, 32'h0);
   endtask : t_osc
   task automatic t_audio();
      logic [3:0] md [4] = '{4'h5, 4'ha, 4'h6, 4'h0};
      for (int m = 0; m < 4; m++) begin
         @(posedge clk);
         cb <= {md[m][3], md[m][1]};
         wr32(8'h90, {24'h0, md[m], 4'h0});
         for (int l = 0; l < 4; l++) begin
            @(posedge clk);
            lvl <= l[1:0];
            cyc(2);
            chk("audio", aud, (l[0] & |md[m][1:0]) ^ (l[1] & |md[m][3:2]));
         end
      end
   endtask : t_audio
   task automatic t_sleep();
      int lsb [4] = '{4, 8, 24, 28};
      for (int k = 0; k < 4; k++) begin
         wr32(8'h8c, 32'h4 << lsb[k]);
         wr32(8'h90, 32'h0f);
         chk("sleep pin", {poe, pin}, {2{4'h1 << k}});
      end
      for (int p = 0; p < 16; p++) begin
         wr32(8'h90, p);
         chk("sleep", pin[3], p[0] & p[1] & (p[2] | p[3]));
      end
   endtask : t_sleep
   task automatic t_led();
      wr32(8'h90, 32'h0);
      wr32(8'h8c, 32'h0000_0320);
      chk("led oe", poe, 4'h3);
      hit(0, 3);
      chk("led0", pin[1:0], 2'b01);
      cyc(LC - 6);
      chk("led hold", pin[0], 1);
      hit(0, LC - 3);
      chk("led retrigger", pin[0], 1);
      cyc(6);
      chk("led off", pin[1:0], 2'b00);
      hit(1, 2);
      rdchk(8'h94, 32'h4);
      chk("led1", pin[1:0], 2'b10);
      for (int k = 0; k < 2; k++) begin
         hit(0, 3);
         @(posedge clk);
         susp <= !k[0];
         stop <= k[0];
         cyc(3);
         chk("led cut", pin[0], 0);
         @(posedge clk);
         susp <= 1'b0;
         stop <= 1'b0;
         cyc(3);
         chk("led cleared", pin[0], 0);
      end
   endtask : t_led
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      cyc(3);
      t_osc();
      t_audio();
      t_sleep();
      t_led();
      report_and_stop();
   end
endmodule : testbench
